// [design/bsd_pkg.sv]
// Package for the branch, byte-set and software interrupt decoder.
// Assumes an upstream fetch unit that presents instruction bytes one a cycle.
package bsd_pkg;
  // Opcode bytes
  localparam logic [7:0] OP_ESCAPE      = 8'h0F;
  localparam logic [3:0] NIB_SHORT_JCC  = 4'h7;
  localparam logic [3:0] NIB_LONG_JCC   = 4'h8;
  localparam logic [3:0] NIB_SET_BYTE   = 4'h9;
  localparam logic [7:0] OP_JCOUNT_ZERO = 8'hE3;
  localparam logic [7:0] OP_LOOP        = 8'hE2;
  localparam logic [7:0] OP_LOOP_ZF     = 8'hE1;
  localparam logic [7:0] OP_LOOP_NZF    = 8'hE0;
  localparam logic [7:0] OP_ENTER       = 8'hC8;
  localparam logic [7:0] OP_LEAVE       = 8'hC9;
  localparam logic [7:0] OP_INT_TYPED   = 8'hCD;
  localparam logic [7:0] OP_INT_BREAK   = 8'hCC;
  localparam logic [7:0] OP_INT_OVF     = 8'hCE;
  localparam logic [7:0] OP_BOUND       = 8'h62;
  localparam logic [2:0] SETB_REG_FIELD = 3'h0;
  localparam logic [1:0] MOD_REGISTER   = 2'h3;
  localparam logic [7:0] ENTER_LEVEL_ZERO = 8'h00;
  localparam logic [7:0] ENTER_LEVEL_ONE  = 8'h01;
  // Vectors
  localparam logic [7:0] VEC_BREAK      = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW   = 8'h04;
  localparam logic [7:0] VEC_BOUND      = 8'h05;
  localparam logic [7:0] VEC_STACK      = 8'h0C;
  localparam logic [7:0] VEC_GENPROT    = 8'h0D;
  // Clock costs
  localparam logic [9:0] CLK_JCC_TAKEN  = 10'h007;
  localparam logic [9:0] CLK_JCC_NOT    = 10'h003;
  localparam logic [9:0] CLK_JCZ_TAKEN  = 10'h009;
  localparam logic [9:0] CLK_JCZ_NOT    = 10'h005;
  localparam logic [9:0] CLK_LOOP       = 10'h00B;
  localparam logic [9:0] CLK_SET_REG    = 10'h004;
  localparam logic [9:0] CLK_SET_MEM    = 10'h005;
  localparam logic [9:0] CLK_ENTER_L0   = 10'h00A;
  localparam logic [9:0] CLK_ENTER_L1   = 10'h00E;
  localparam logic [9:0] CLK_ENTER_BASE = 10'h011;
  localparam logic [9:0] CLK_ENTER_STEP = 10'h008;
  localparam logic [9:0] CLK_LEAVE      = 10'h004;
  localparam logic [9:0] CLK_INT_TYPED  = 10'h025;
  localparam logic [9:0] CLK_INT_BREAK  = 10'h021;
  localparam logic [9:0] CLK_INTO_TAKEN = 10'h023;
  localparam logic [9:0] CLK_INTO_NOT   = 10'h003;
  localparam logic [9:0] CLK_BOUND_OUT  = 10'h02C;
  localparam logic [9:0] CLK_BOUND_IN   = 10'h00A;
  localparam logic [9:0] CLK_PM_SAME    = 10'h047;
  localparam logic [9:0] CLK_PM_CHANGE  = 10'h06F;
  localparam logic [9:0] CLK_V86_TO_PL0 = 10'h113;
  // Condition codes
  localparam logic [3:0] CC_OVF  = 4'h0;
  localparam logic [3:0] CC_B    = 4'h2;
  localparam logic [3:0] CC_E    = 4'h4;
  localparam logic [3:0] CC_BE   = 4'h6;
  localparam logic [3:0] CC_S    = 4'h8;
  localparam logic [3:0] CC_P    = 4'hA;
  localparam logic [3:0] CC_L    = 4'hC;
  localparam logic [3:0] CC_LE   = 4'hE;

  typedef enum logic [1:0] {
    BSD_MODE_REAL = 2'h0,
    BSD_MODE_V86  = 2'h1,
    BSD_MODE_PROT = 2'h2
  } bsd_mode_t;

  typedef enum logic [7:0] {
    BSD_ST_OP     = 8'h01,
    BSD_ST_ESC    = 8'h02,
    BSD_ST_DISP   = 8'h04,
    BSD_ST_MODRM  = 8'h08,
    BSD_ST_FRAME  = 8'h10,
    BSD_ST_LEVEL  = 8'h20,
    BSD_ST_TYPE   = 8'h40,
    BSD_ST_DONE   = 8'h80
  } bsd_state_t;
endpackage

// [design/bsd_decoder.sv]
// Decoder and clock-cost logic for branch, byte-set, frame and
// software interrupt instructions.
// Assumes bytes arrive one per cycle with byteValid, flags and mode stable
// for the instruction, and that execution results (bound check, limit
// faults, gate kind) are presented as inputs when the last byte arrives.
`timescale 1ns/1ps
// What this block does
// - Short jump: 0111 nibble, condition, 8-bit displacement
// - Long jump: escape, 1000 nibble, full displacement
// - Condition nibble selects flag test
// - Conditional jump costs seven plus m or three
// - Count-zero jump: nine plus m or five
// - Counted loop costs eleven plus m
// - Zero-flag loops cost eleven plus m
// - Byte-set: escape, 1001 nibble, reg 000; 4/5
// - Frame enter: 10, 14, 17 plus 8 per level above one
// - Frame leave costs four clocks
// - Overflow interrupt vector 4 at 35, else 3
// - Bound check: vector 5 at 44, else 10
// - Protected gate: 71 same, 111 changed privilege
// - Typed interrupt from v86 to level 0: 275
// - Protected limit fault 13, stack fault 12
module bsd_decoder #(
  parameter int DISP_BYTES_FULL = 4
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               sys_rst,
  input  wire logic               clkEn,
  // Instruction byte stream
  input  wire logic               byteValid,
  input  wire logic [7:0]         instrByte,
  input  wire logic               addrSize32,
  input  wire bsd_pkg::bsd_mode_t cpuMode,
  // Arithmetic flags
  input  wire logic               carryFlag,
  input  wire logic               zeroFlag,
  input  wire logic               signFlag,
  input  wire logic               parityFlag,
  input  wire logic               overflow_flag,
  // Execution results
  input  wire logic               countIsZero16,
  input  wire logic               countIsZero32,
  input  wire logic               countAfterDecNonZero,
  input  wire logic               boundOutOfRange,
  input  wire logic               gatePrivChange,
  input  wire logic               segLimitFault,
  input  wire logic               stackLimitFault,
  input  wire logic [3:0]         targetComponents,
  // Results
  output logic                    doneValid,
  output logic                    branchTaken,
  output logic [9:0]              clockCost,
  output logic                    intRaise,
  output logic [7:0]              intVector,
  output logic                    setByteValue,
  output logic                    setByteToMem
);
  import bsd_pkg::*;

  bsd_state_t  state_reg;
  logic [7:0]  opcode_reg;
  logic        isLong_reg;
  logic [2:0]  byteCnt_reg;
  logic [3:0]  cond_reg;
  logic        condTrue;
  logic        lastByte;
  logic        takenNext;
  logic        intNext;
  logic [7:0]  vecNext;
  logic [9:0]  costNext;
  logic [9:0]  mCost;
  logic [9:0]  levelCost;
  logic        isShortJcc;
  logic [2:0]  dispLen;

  assign isShortJcc = (instrByte[7:4] == NIB_SHORT_JCC);
  assign mCost = {6'h00, targetComponents};
  assign dispLen = isLong_reg ? 3'(DISP_BYTES_FULL) : 3'h1;

  // Flag test, low bit inverts the sense
  always_comb begin
    logic base;
    base = 1'b0;
    unique case ({cond_reg[3:1], 1'b0})
      CC_OVF:  base = overflow_flag;
      CC_B:    base = carryFlag;
      CC_E:    base = zeroFlag;
      CC_BE:   base = carryFlag | zeroFlag;
      CC_S:    base = signFlag;
      CC_P:    base = parityFlag;
      CC_L:    base = signFlag ^ overflow_flag;
      CC_LE:   base = (signFlag ^ overflow_flag) | zeroFlag;
      default: base = 1'b0;
    endcase
    condTrue = base ^ cond_reg[0];
  end

  // Sequencer
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg   <= BSD_ST_OP;
      opcode_reg  <= 8'h00;
      isLong_reg  <= 1'b0;
      byteCnt_reg <= 3'h0;
      cond_reg    <= 4'h0;
    end else if (clkEn && byteValid) begin
      byteCnt_reg <= byteCnt_reg + 3'h1;
      unique case (state_reg)
        BSD_ST_OP, BSD_ST_DONE: begin
          opcode_reg  <= instrByte;
          isLong_reg  <= 1'b0;
          byteCnt_reg <= 3'h0;
          cond_reg    <= instrByte[3:0];
          if (instrByte == OP_ESCAPE)
            state_reg <= BSD_ST_ESC;
          else if (isShortJcc || instrByte == OP_JCOUNT_ZERO ||
                   instrByte == OP_LOOP || instrByte == OP_LOOP_ZF ||
                   instrByte == OP_LOOP_NZF)
            state_reg <= BSD_ST_DISP;
          else if (instrByte == OP_ENTER)
            state_reg <= BSD_ST_FRAME;
          else if (instrByte == OP_INT_TYPED)
            state_reg <= BSD_ST_TYPE;
          else if (instrByte == OP_BOUND)
            state_reg <= BSD_ST_MODRM;
          else if (instrByte == OP_LEAVE || instrByte == OP_INT_BREAK ||
                   instrByte == OP_INT_OVF)
            state_reg <= BSD_ST_DONE;
          else
            state_reg <= BSD_ST_OP;
        end
        BSD_ST_ESC: begin
          opcode_reg  <= instrByte;
          cond_reg    <= instrByte[3:0];
          byteCnt_reg <= 3'h0;
          if (instrByte[7:4] == NIB_LONG_JCC) begin
            isLong_reg <= 1'b1;
            state_reg  <= BSD_ST_DISP;
          end else if (instrByte[7:4] == NIB_SET_BYTE)
            state_reg <= BSD_ST_MODRM;
          else
            state_reg <= BSD_ST_OP;
        end
        BSD_ST_DISP:
          state_reg <= lastByte ? BSD_ST_DONE : BSD_ST_DISP;
        BSD_ST_MODRM:
          state_reg <= BSD_ST_DONE;
        BSD_ST_FRAME: begin
          byteCnt_reg <= 3'h1;
          if (byteCnt_reg == 3'h1) state_reg <= BSD_ST_LEVEL;
        end
        BSD_ST_LEVEL, BSD_ST_TYPE:
          state_reg <= BSD_ST_DONE;
      endcase
    end
  end

  // Final byte of the instruction in this cycle
  always_comb begin
    lastByte = 1'b0;
    unique case (state_reg)
      BSD_ST_DISP:  lastByte = (byteCnt_reg == dispLen - 3'h1);
      BSD_ST_MODRM: lastByte = (opcode_reg[7:4] != NIB_SET_BYTE) ||
                               (instrByte[5:3] == SETB_REG_FIELD);
      BSD_ST_LEVEL, BSD_ST_TYPE: lastByte = 1'b1;
      BSD_ST_OP, BSD_ST_DONE:
        lastByte = (instrByte == OP_LEAVE) || (instrByte == OP_INT_BREAK) ||
                   (instrByte == OP_INT_OVF);
      default:      lastByte = 1'b0;
    endcase
  end

  // Frame enter cost, level taken from the current byte
  always_comb begin
    levelCost = CLK_ENTER_BASE + 10'(({2'h0, instrByte} -
      {2'h0, ENTER_LEVEL_ONE}) * CLK_ENTER_STEP);
    if (instrByte == ENTER_LEVEL_ZERO) levelCost = CLK_ENTER_L0;
    else if (instrByte == ENTER_LEVEL_ONE) levelCost = CLK_ENTER_L1;
  end

  // Outcome of the instruction that ends now
  always_comb begin
    takenNext = 1'b0;
    intNext   = 1'b0;
    vecNext   = 8'h00;
    costNext  = 10'h000;
    if (state_reg == BSD_ST_DISP) begin
      if (opcode_reg == OP_JCOUNT_ZERO) begin
        takenNext = addrSize32 ? countIsZero32 : countIsZero16;
        costNext = takenNext ? CLK_JCZ_TAKEN + mCost : CLK_JCZ_NOT;
      end else if (opcode_reg[7:2] == OP_LOOP_NZF[7:2]) begin
        takenNext = countAfterDecNonZero &&
          (opcode_reg == OP_LOOP || (opcode_reg == OP_LOOP_ZF) == zeroFlag);
        costNext = CLK_LOOP + mCost;
      end else begin
        takenNext = condTrue;
        costNext = condTrue ? CLK_JCC_TAKEN + mCost : CLK_JCC_NOT;
      end
    end else if (state_reg == BSD_ST_MODRM) begin
      if (opcode_reg == OP_BOUND) begin
        intNext = boundOutOfRange;
        vecNext = VEC_BOUND;
        costNext = boundOutOfRange ? CLK_BOUND_OUT : CLK_BOUND_IN;
      end else
        costNext = (instrByte[7:6] != MOD_REGISTER) ? CLK_SET_MEM
                                                     : CLK_SET_REG;
    end else if (state_reg == BSD_ST_LEVEL) begin
      costNext = levelCost;
    end else if (state_reg == BSD_ST_TYPE) begin
      intNext = 1'b1;
      vecNext = instrByte;
      if (cpuMode == BSD_MODE_V86)
        costNext = CLK_V86_TO_PL0;
      else if (cpuMode == BSD_MODE_PROT)
        costNext = gatePrivChange ? CLK_PM_CHANGE : CLK_PM_SAME;
      else
        costNext = CLK_INT_TYPED;
    end else if (instrByte == OP_LEAVE) begin
      costNext = CLK_LEAVE;
    end else if (instrByte == OP_INT_BREAK) begin
      intNext = 1'b1;
      vecNext = VEC_BREAK;
      costNext = (cpuMode == BSD_MODE_PROT) ?
        (gatePrivChange ? CLK_PM_CHANGE : CLK_PM_SAME) : CLK_INT_BREAK;
    end else begin
      intNext = overflow_flag;
      vecNext = VEC_OVERFLOW;
      costNext = overflow_flag ? ((cpuMode == BSD_MODE_PROT) ?
        (gatePrivChange ? CLK_PM_CHANGE : CLK_PM_SAME) : CLK_INTO_TAKEN)
        : CLK_INTO_NOT;
    end
    // Memory operand faults outrank the instruction's own event
    if (cpuMode == BSD_MODE_PROT && state_reg == BSD_ST_MODRM &&
        instrByte[7:6] != MOD_REGISTER &&
        (segLimitFault || stackLimitFault)) begin
      intNext = 1'b1;
      vecNext = stackLimitFault ? VEC_STACK : VEC_GENPROT;
    end
  end

  // Registered results, one-cycle pulse per finished instruction
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      doneValid    <= 1'b0;
      branchTaken  <= 1'b0;
      clockCost    <= 10'h000;
      intRaise     <= 1'b0;
      intVector    <= 8'h00;
      setByteValue <= 1'b0;
      setByteToMem <= 1'b0;
    end else if (clkEn) begin
      doneValid <= byteValid && lastByte;
      if (byteValid && lastByte) begin
        branchTaken  <= takenNext;
        clockCost    <= costNext;
        intRaise     <= intNext;
        intVector    <= vecNext;
        setByteValue <= condTrue;
        setByteToMem <= (instrByte[7:6] != MOD_REGISTER);
      end
    end
  end

  AST_JCC_COST: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && lastByte && state_reg == BSD_ST_DISP &&
    opcode_reg[7:4] != OP_LOOP[7:4] && !condTrue |=> clockCost == CLK_JCC_NOT)
    else $error("untaken jump cost wrong");
  AST_LEAVE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && state_reg inside {BSD_ST_OP, BSD_ST_DONE} &&
    instrByte == OP_LEAVE
    |=> doneValid && clockCost == CLK_LEAVE)
    else $error("leave cost wrong");
  AST_INTO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && state_reg inside {BSD_ST_OP, BSD_ST_DONE} &&
    instrByte == OP_INT_OVF
    |=> intRaise == $past(overflow_flag))
    else $error("overflow interrupt wrong");
  AST_BOUND: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && state_reg == BSD_ST_MODRM && opcode_reg == OP_BOUND
    && cpuMode != BSD_MODE_PROT && boundOutOfRange
    |=> intVector == VEC_BOUND && clockCost == CLK_BOUND_OUT)
    else $error("bound fault wrong");
  AST_BREAK: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && state_reg inside {BSD_ST_OP, BSD_ST_DONE} &&
    instrByte == OP_INT_BREAK && cpuMode == BSD_MODE_REAL
    |=> intVector == VEC_BREAK && clockCost == CLK_INT_BREAK)
    else $error("breakpoint wrong");
  AST_V86: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && state_reg == BSD_ST_TYPE && cpuMode == BSD_MODE_V86
    |=> clockCost == CLK_V86_TO_PL0)
    else $error("v86 interrupt cost wrong");
  AST_PM: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && state_reg == BSD_ST_TYPE &&
    cpuMode == BSD_MODE_PROT && gatePrivChange |=> clockCost == CLK_PM_CHANGE)
    else $error("gate cost wrong");
  AST_LOOP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && lastByte && state_reg == BSD_ST_DISP &&
    opcode_reg == OP_LOOP |=> clockCost == CLK_LOOP + $past(mCost))
    else $error("loop cost wrong");
  AST_ENTER: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && byteValid && state_reg == BSD_ST_LEVEL &&
    instrByte > ENTER_LEVEL_ONE |=> clockCost == CLK_ENTER_BASE +
    CLK_ENTER_STEP * (10'($past(instrByte)) - 10'(ENTER_LEVEL_ONE)))
    else $error("frame enter cost wrong");
endmodule // bsd_decoder

// [sim/testbench.sv]
// Self-checking bench for the branch, byte-set and interrupt decoder.
// Drives the byte stream and flag inputs directly; no partner model.
`timescale 1ns/1ps
module testbench;
  import bsd_pkg::*;
  localparam int FULL = 4;
  logic       ref_clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1;
  logic       byteValid = 1'b0, addrSize32 = 1'b0;
  logic [7:0] instrByte = 8'h00;
  bsd_mode_t  cpuMode = BSD_MODE_REAL;
  logic       carryFlag = 0, zeroFlag = 0, signFlag = 0, parityFlag = 0;
  logic       overflow_flag = 0, countIsZero16 = 0, countIsZero32 = 0;
  logic       countAfterDecNonZero = 0, boundOutOfRange = 0;
  logic       gatePrivChange = 0, segLimitFault = 0, stackLimitFault = 0;
  logic [3:0] targetComponents = 4'h2;
  logic       doneValid, branchTaken, intRaise, setByteValue, setByteToMem;
  logic [9:0] clockCost;
  logic [7:0] intVector;
  logic [7:0] bq[$];
  int         failures = 0, checks_done = 0;

  bsd_decoder #(.DISP_BYTES_FULL(FULL)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .byteValid(byteValid), .instrByte(instrByte),
    .addrSize32(addrSize32), .cpuMode(cpuMode), .carryFlag(carryFlag),
    .zeroFlag(zeroFlag), .signFlag(signFlag), .parityFlag(parityFlag),
    .overflow_flag(overflow_flag), .countIsZero16(countIsZero16),
    .countIsZero32(countIsZero32),
    .countAfterDecNonZero(countAfterDecNonZero),
    .boundOutOfRange(boundOutOfRange), .gatePrivChange(gatePrivChange),
    .segLimitFault(segLimitFault), .stackLimitFault(stackLimitFault),
    .targetComponents(targetComponents), .doneValid(doneValid),
    .branchTaken(branchTaken), .clockCost(clockCost),
    .intRaise(intRaise), .intVector(intVector),
    .setByteValue(setByteValue), .setByteToMem(setByteToMem));

  always #25 ref_clk = ~ref_clk;

  task automatic check(input string name, input logic [9:0] seen,
                       input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Independent flag test, used as the reference for every condition
  function automatic logic cond_ok(input logic [3:0] cc);
    logic r;
    case (cc[3:1])
      3'h0: r = overflow_flag;
      3'h1: r = carryFlag;
      3'h2: r = zeroFlag;
      3'h3: r = carryFlag | zeroFlag;
      3'h4: r = signFlag;
      3'h5: r = parityFlag;
      3'h6: r = signFlag ^ overflow_flag;
      default: r = (signFlag ^ overflow_flag) | zeroFlag;
    endcase
    return r ^ cc[0];
  endfunction

  // Sends bq, waits for completion; chk picks taken, cost, interrupt
  task automatic run(input logic [2:0] chk, input logic tk,
                     input logic [9:0] cost, input logic irq,
                     input logic [7:0] vec);
    int k;
    foreach (bq[i]) begin
      byteValid = 1'b1;
      instrByte = bq[i];
      @(posedge ref_clk);
      #1;
    end
    byteValid = 1'b0;
    for (k = 0; k < 4 && doneValid !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    check("doneValid", doneValid, 1);
    if (chk[0]) check("branchTaken", branchTaken, tk);
    if (chk[1]) check("clockCost", clockCost, cost);
    if (chk[2]) check("intRaise", intRaise, irq);
    if (chk[2] && irq) check("intVector", intVector, vec);
    @(posedge ref_clk);
    #1;
    check("doneValid pulse", doneValid, 0);
  endtask

  task automatic t_jcc();
    logic t;
    for (int cc = 0; cc < 16; cc++) begin
      for (int p = 0; p < 32; p++) begin
        {carryFlag, zeroFlag, signFlag, parityFlag, overflow_flag} = 5'(p);
        targetComponents = 4'(p % 5 + 1);
        t = cond_ok(4'(cc));
        bq = '{8'h70 | 8'(cc), 8'hFE};
        run(3'h3, t, t ? 10'h007 + 10'(targetComponents) : 10'h003, 0, 0);
        bq = '{8'h0F, 8'h80 | 8'(cc), 8'h10, 8'h00, 8'h00, 8'h80};
        run(3'h3, t, t ? 10'h007 + 10'(targetComponents) : 10'h003, 0, 0);
      end
    end
  endtask

  task automatic t_count_loops();
    logic t;
    targetComponents = 4'h3;
    for (int p = 0; p < 8; p++) begin
      {addrSize32, countIsZero16, countIsZero32} = 3'(p);
      t = addrSize32 ? countIsZero32 : countIsZero16;
      bq = '{8'hE3, 8'h05};
      run(3'h3, t, t ? 10'h00C : 10'h005, 0, 0);
    end
    for (int p = 0; p < 4; p++) begin
      {countAfterDecNonZero, zeroFlag} = 2'(p);
      bq = '{8'hE2, 8'hF0};
      run(3'h3, countAfterDecNonZero, 10'h00E, 0, 0);
      bq = '{8'hE1, 8'hF0};
      run(3'h3, countAfterDecNonZero & zeroFlag, 10'h00E, 0, 0);
      bq = '{8'hE0, 8'hF0};
      run(3'h3, countAfterDecNonZero & ~zeroFlag, 10'h00E, 0, 0);
    end
  endtask

  task automatic t_set_byte();
    for (int cc = 0; cc < 16; cc++) begin
      {carryFlag, zeroFlag, signFlag, parityFlag, overflow_flag} = 5'(cc * 3);
      bq = '{8'h0F, 8'h90 | 8'(cc), 8'hC1};
      run(3'h2, 0, 10'h004, 0, 0);
      check("setByteValue", setByteValue, cond_ok(4'(cc)));
      check("setByteToMem", setByteToMem, 0);
      bq = '{8'h0F, 8'h90 | 8'(cc), 8'h06};
      run(3'h2, 0, 10'h005, 0, 0);
      check("setByteToMem", setByteToMem, 1);
    end
  endtask

  task automatic t_frames_ints();
    logic [7:0] lv[4] = '{8'h00, 8'h01, 8'h02, 8'h05};
    logic [9:0] ec[4] = '{10'h00A, 10'h00E, 10'h019, 10'h031};
    for (int i = 0; i < 4; i++) begin
      bq = '{8'hC8, 8'h20, 8'h00, lv[i]};
      run(3'h2, 0, ec[i], 0, 0);
    end
    bq = '{8'hC9};
    run(3'h2, 0, 10'h004, 0, 0);
    // Enable low: a complete one-byte instruction must not finish
    clkEn = 1'b0;
    byteValid = 1'b1;
    instrByte = 8'hC9;
    @(posedge ref_clk);
    #1;
    {clkEn, byteValid} = 2'b10;
    check("doneValid while frozen", doneValid, 0);
    @(posedge ref_clk);
    #1;
    bq = '{8'hCD, 8'h21};
    run(3'h6, 0, 10'h025, 1, 8'h21);
    bq = '{8'hCC};
    run(3'h6, 0, 10'h021, 1, 8'h03);
    overflow_flag = 1'b1;
    bq = '{8'hCE};
    run(3'h6, 0, 10'h023, 1, 8'h04);
    overflow_flag = 1'b0;
    run(3'h6, 0, 10'h003, 0, 0);
    boundOutOfRange = 1'b1;
    bq = '{8'h62, 8'h06};
    run(3'h6, 0, 10'h02C, 1, 8'h05);
    boundOutOfRange = 1'b0;
    run(3'h6, 0, 10'h00A, 0, 0);
  endtask

  task automatic t_protected();
    cpuMode = BSD_MODE_PROT;
    gatePrivChange = 1'b0;
    bq = '{8'hCD, 8'h40};
    run(3'h6, 0, 10'h047, 1, 8'h40);
    gatePrivChange = 1'b1;
    run(3'h6, 0, 10'h06F, 1, 8'h40);
    segLimitFault = 1'b1;
    bq = '{8'h0F, 8'h94, 8'h06};
    run(3'h4, 0, 0, 1, 8'h0D);
    stackLimitFault = 1'b1;
    run(3'h4, 0, 0, 1, 8'h0C);
    {segLimitFault, stackLimitFault} = 2'b00;
    cpuMode = BSD_MODE_V86;
    bq = '{8'hCD, 8'h10};
    run(3'h6, 0, 10'h113, 1, 8'h10);
    cpuMode = BSD_MODE_REAL;
    gatePrivChange = 1'b0;
  endtask

  // Roughly 1100 instructions of under ten cycles each
  initial begin
    #(50 * 80000);
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    check("doneValid in reset", doneValid, 0);
    check("clockCost in reset", clockCost, 0);
    sys_rst = 1'b0;
    t_jcc();
    t_count_loops();
    t_set_byte();
    t_frames_ints();
    t_protected();
    tally_and_finish();
  end
endmodule // testbench
